// File: rtl/cmc_pkg.sv
// Constants for the charger mode control word block: command code, field layout,
// reset value, status bit positions and threshold scaling.
// Assumes only that the design files name everything as cmc_pkg::name.
`default_nettype none

package cmc_pkg;
	// Command code that addresses the mode control word
	localparam logic [7:0] CMD_CHARGER_MODE = 8'h12;

	// Field positions of the mode control word
	localparam int BIT_CHARGE_STOP = 0;
	localparam int BIT_RESTORE = 2;
	localparam int BIT_MON_SEL = 3;
	localparam int BIT_LEARN = 4;
	localparam int BIT_FREQ = 5;
	localparam int BIT_GUARD = 6;
	localparam int RATIO_LSB = 7;
	localparam int DEPL_LSB = 9;

	// Stored bits: restore bit is a one-shot, bits 1 and 12 to 15 are unused
	localparam logic [15:0] CTRL_STORE_MASK = 16'h0FF9;
	// Power-on value: charger stopped, adapter amp on monitor, 300 kHz, guard off
	localparam logic [15:0] CTRL_RESET = 16'h0001;

	// Status word bit positions
	localparam int ST_CHARGER_OFF = 1;
	localparam int ST_ON_BATTERY = 6;
	localparam int ST_BATT_LOW_ON_BATTERY = 7;
	localparam int ST_CELL_DEPLETED = 11;

	// Overcurrent ratio in tenths for codes 00, 01, 10, 11
	localparam logic [4:0] RATIO_X10_0 = 5'h0D;
	localparam logic [4:0] RATIO_X10_1 = 5'h0F;
	localparam logic [4:0] RATIO_X10_2 = 5'h11;
	localparam logic [4:0] RATIO_X10_3 = 5'h13;
	localparam logic [20:0] RATIO_DIVISOR = 21'h00000A;

	// Depleted-cell threshold in millivolts: base plus step per code
	localparam logic [11:0] DEPL_BASE_MV = 12'h898;
	localparam logic [11:0] DEPL_STEP_MV = 12'h064;

	// Synchroniser depth for pin inputs
	localparam int SYNC_STAGES = 2;
endpackage

`default_nettype wire

// File: rtl/cmc_sync.sv
// Two-flop synchroniser bank for asynchronous pin levels.
// Assumes inputs are slow levels; a pulse shorter than one clock may be lost.
`default_nettype none

module cmc_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] meta_next;
	logic [WIDTH-1:0] sync_reg;
	logic [WIDTH-1:0] sync_next;

	// Refuse a bank with no bits at elaboration
	if (WIDTH < 1) begin : g_width_check
		$error("cmc_sync: WIDTH must be at least 1");
	end

	// First stage feeds only the second stage
	always_comb begin
		meta_next = async_in;
		sync_next = meta_reg;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_reg <= RESET_VALUE;
			sync_reg <= RESET_VALUE;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
		end
	end

	assign sync_out = sync_reg;
endmodule

`default_nettype wire

// File: rtl/cmc_mode_ctrl.sv
// Charger mode control word: decodes host writes, drives charger controls,
// builds the status bits it influences and the open-drain alert.
// Assumes the command interface delivers decoded word writes on CLK_SYS and
// that the input-limit value comes from logic on the same clock.
//
// Functional notes
// R01 - Charger runs only when stop bit and enable pin are both low.
// R02 - Stop bit effect shows in charger-off status bit 1.
// R03 - Bits 1, 12, 13 to 15 are unused and held at zero.
// R04 - Writing bit 2 high restores power-on values; writing zero does nothing.
// R05 - Bit 3 picks charge (1) or adapter (0) sense amplifier for monitor.
// R06 - After power-up the monitor carries the adapter current amplifier.
// R07 - Bit 4 high runs system from battery for a learn cycle.
// R08 - Learn bit influences status bits 6 and 7.
// R09 - Bit 5 selects 500 kHz when high, 300 kHz when low.
// R10 - Bit 6 enables adapter overcurrent guard.
// R11 - Ratio field scales trip by 1.3/1.5/1.7/1.9, only while guard on.
// R12 - Trip threshold derives from the separately held input current limit.
// R13 - Depleted field sets 2.2 V to 2.9 V per cell, 0.1 V steps.
// R14 - Depleted field influences status bits 11, 6 and 7; code feeds only bits 11 and 7 from CELL_BELOW_DEPLETED.
// R15 - Word written with command 0x12; no read path exists.
// R16 - Host sets 19.2 V regulation for constant-current-only packs.
// R17 - Any status change pulls alert low until the status word is read.
// R18 - Restore bit is one-shot and never stored.
`default_nettype none

module cmc_mode_ctrl (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RST_B,
	// Word writes from the command interface
	input wire logic WR_VALID,
	input wire logic [7:0] WR_CMD,
	input wire logic [15:0] WR_DATA,
	// Status read notice from the command interface
	input wire logic STATUS_RD,
	// Input current limit in mA from the limit register
	input wire logic [15:0] INPUT_CURRENT_LIMIT,
	// Pins and comparators, asynchronous
	input wire logic CHARGE_ENABLE_PIN_N,
	input wire logic ADAPTER_PRESENT,
	input wire logic CELL_BELOW_DEPLETED,
	// Charger controls
	output logic CHARGER_EN,
	output logic RESTORE_DEFAULTS,
	output logic CURRENT_MONITOR_OUT_SEL_CHARGE,
	output logic LEARN_CYCLE,
	output logic SWITCH_FREQ_SEL,
	output logic ADAPTER_OVERCURRENT_GUARD,
	output logic [1:0] OVERCURRENT_RATIO_SEL,
	output logic [15:0] OVERCURRENT_TRIP_MA,
	output logic [2:0] DEPLETED_CELL_THRESHOLD,
	output logic [11:0] DEPLETED_CELL_MV,
	// Status bits influenced here
	output logic [15:0] STATUS_BITS,
	// Open-drain alert
	output logic ALERT_N_O,
	output logic ALERT_N_OE
);
	logic pin_n_sync;
	logic adapter_sync;
	logic cell_low_sync;
	logic [15:0] ctrl_reg;
	logic [15:0] ctrl_next;
	logic restore_reg;
	logic restore_next;
	logic en_reg;
	logic en_next;
	logic [15:0] trip_reg;
	logic [15:0] trip_next;
	logic [11:0] depl_mv_reg;
	logic [11:0] depl_mv_next;
	logic [15:0] status_reg;
	logic [15:0] status_next;
	logic alert_reg;
	logic alert_next;
	logic write_hit;
	logic on_battery;

	// Sense pin levels cross two flops; the enable pin resets high (stopped)
	cmc_sync #(
		.WIDTH(1),
		.RESET_VALUE(1'b1)
	) u_sync_pin (
		.clk(CLK_SYS),
		.rst_b(RST_B),
		.async_in(CHARGE_ENABLE_PIN_N),
		.sync_out(pin_n_sync)
	);

	// Adapter resets as present so an idle adapter raises no false alert after reset
	cmc_sync #(
		.WIDTH(2),
		.RESET_VALUE(2'h2)
	) u_sync_sense (
		.clk(CLK_SYS),
		.rst_b(RST_B),
		.async_in({ADAPTER_PRESENT, CELL_BELOW_DEPLETED}),
		.sync_out({adapter_sync, cell_low_sync})
	);

	function automatic logic [4:0] ratio_x10(input logic [1:0] code);
		logic [4:0] r;
		r = cmc_pkg::RATIO_X10_0;
		unique case (code)
			2'h0: r = cmc_pkg::RATIO_X10_0;
			2'h1: r = cmc_pkg::RATIO_X10_1;
			2'h2: r = cmc_pkg::RATIO_X10_2;
			2'h3: r = cmc_pkg::RATIO_X10_3;
		endcase
		return r;
	endfunction

	// Trip in mA; saturates rather than wrapping for oversized limits
	function automatic logic [15:0] trip_ma(input logic [15:0] limit, input logic [1:0] code);
		logic [20:0] prod;
		logic [20:0] quot;
		prod = 21'({5'h00, limit} * {16'h0000, ratio_x10(code)});
		quot = prod / cmc_pkg::RATIO_DIVISOR;
		if (quot[20:16] != 5'h00) begin
			return 16'hFFFF;
		end
		return quot[15:0];
	endfunction

	// Control word
	always_comb begin
		// R15 write decode
		write_hit = WR_VALID && (WR_CMD == cmc_pkg::CMD_CHARGER_MODE);
		ctrl_next = ctrl_reg;
		restore_next = 1'b0;
		if (write_hit) begin
			if (WR_DATA[cmc_pkg::BIT_RESTORE]) begin
				// Other data bits of a restore write are ignored
				// R04 restore defaults
				// R06 adapter amp default
				ctrl_next = cmc_pkg::CTRL_RESET;
				restore_next = 1'b1;
			end else begin
				// R03 unused bits zero
				// R18 restore not stored
				ctrl_next = WR_DATA & cmc_pkg::CTRL_STORE_MASK;
			end
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			ctrl_reg <= cmc_pkg::CTRL_RESET;
			restore_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			restore_reg <= restore_next;
		end
	end

	// Derived controls, status and alert
	always_comb begin
		// R01 stop bit and pin
		en_next = !ctrl_reg[cmc_pkg::BIT_CHARGE_STOP] && !pin_n_sync;
		// Recomputed every cycle so a new input limit needs no rewrite
		// R11 ratio applies only with guard on
		// R12 scaled from input limit
		if (ctrl_reg[cmc_pkg::BIT_GUARD]) begin
			trip_next = trip_ma(INPUT_CURRENT_LIMIT, ctrl_reg[cmc_pkg::RATIO_LSB +: 2]);
		end else begin
			trip_next = 16'h0000;
		end
		// R13 per-cell threshold
		depl_mv_next = cmc_pkg::DEPL_BASE_MV
			+ 12'(ctrl_reg[cmc_pkg::DEPL_LSB +: 3] * cmc_pkg::DEPL_STEP_MV);
		// R08 learn forces battery path
		on_battery = ctrl_reg[cmc_pkg::BIT_LEARN] || !adapter_sync;
		status_next = 16'h0000;
		// R02 charger-off flag
		status_next[cmc_pkg::ST_CHARGER_OFF] = !en_next;
		status_next[cmc_pkg::ST_ON_BATTERY] = on_battery;
		// R14 CELL_BELOW_DEPLETED feeds status bits 11 and 7
		status_next[cmc_pkg::ST_BATT_LOW_ON_BATTERY] = on_battery && cell_low_sync;
		status_next[cmc_pkg::ST_CELL_DEPLETED] = cell_low_sync;
		// A change in the read cycle must not be lost
		// R17 change sets alert; set beats read clear
		alert_next = (status_next != status_reg) || (alert_reg && !STATUS_RD);
	end

	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			en_reg <= 1'b0;
			trip_reg <= 16'h0000;
			depl_mv_reg <= cmc_pkg::DEPL_BASE_MV;
			status_reg <= 16'h0002;
			alert_reg <= 1'b0;
		end else begin
			en_reg <= en_next;
			trip_reg <= trip_next;
			depl_mv_reg <= depl_mv_next;
			status_reg <= status_next;
			alert_reg <= alert_next;
		end
	end

	assign CHARGER_EN = en_reg;
	assign RESTORE_DEFAULTS = restore_reg;
	// R05 monitor source select
	assign CURRENT_MONITOR_OUT_SEL_CHARGE = ctrl_reg[cmc_pkg::BIT_MON_SEL];
	// R07 learn cycle path
	assign LEARN_CYCLE = ctrl_reg[cmc_pkg::BIT_LEARN];
	// R09 frequency select
	assign SWITCH_FREQ_SEL = ctrl_reg[cmc_pkg::BIT_FREQ];
	// R10 guard enable
	assign ADAPTER_OVERCURRENT_GUARD = ctrl_reg[cmc_pkg::BIT_GUARD];
	assign OVERCURRENT_RATIO_SEL = ctrl_reg[cmc_pkg::RATIO_LSB +: 2];
	assign OVERCURRENT_TRIP_MA = trip_reg;
	assign DEPLETED_CELL_THRESHOLD = ctrl_reg[cmc_pkg::DEPL_LSB +: 3];
	assign DEPLETED_CELL_MV = depl_mv_reg;
	assign STATUS_BITS = status_reg;
	// Open drain only ever pulls low
	assign ALERT_N_O = 1'b0;
	assign ALERT_N_OE = alert_reg;
endmodule

`default_nettype wire

// File: rtl/_end.sv
`default_nettype wire

// File: verif/cmc_mode_ctrl_monitor.sv
// Checker for the charger mode control word block.
// Assumes it is bound into cmc_mode_ctrl and sees its ports only.
`default_nettype none

module cmc_mode_ctrl_monitor (
	// Clock, reset, requests
	input wire logic CLK_SYS,
	input wire logic RST_B,
	input wire logic WR_VALID,
	input wire logic [7:0] WR_CMD,
	input wire logic [15:0] WR_DATA,
	input wire logic STATUS_RD,
	input wire logic CHARGE_ENABLE_PIN_N,
	// Outputs
	input wire logic CHARGER_EN,
	input wire logic RESTORE_DEFAULTS,
	input wire logic SWITCH_FREQ_SEL,
	input wire logic ADAPTER_OVERCURRENT_GUARD,
	input wire logic [15:0] OVERCURRENT_TRIP_MA,
	input wire logic [2:0] DEPLETED_CELL_THRESHOLD,
	input wire logic [11:0] DEPLETED_CELL_MV,
	input wire logic [15:0] STATUS_BITS,
	input wire logic ALERT_N_OE
);
	default clocking @(posedge CLK_SYS);
	endclocking
	default disable iff (!RST_B);
	wire logic take = WR_VALID && WR_CMD == 8'h12;
	wire logic rq = take && WR_DATA[2];
	wire logic [4:0] fld = {WR_DATA[11:9], WR_DATA[6:5]};
	AST_PIN: assert property (CHARGER_EN |-> !$past(CHARGE_ENABLE_PIN_N, 3))
		else $error("charger on with pin high");
	AST_PULSE: assert property (RESTORE_DEFAULTS |-> $past(rq))
		else $error("restore without request");
	AST_RESTORE: assert property (rq |=> RESTORE_DEFAULTS && !SWITCH_FREQ_SEL ##1 !CHARGER_EN)
		else $error("restore values");
	AST_FIELDS: assert property (take && !WR_DATA[2] |=>
		{DEPLETED_CELL_THRESHOLD, ADAPTER_OVERCURRENT_GUARD, SWITCH_FREQ_SEL} == $past(fld))
		else $error("fields");
	AST_TRIP_OFF: assert property (!$past(ADAPTER_OVERCURRENT_GUARD) |-> !OVERCURRENT_TRIP_MA)
		else $error("trip while guard off");
	AST_MV: assert property (DEPLETED_CELL_MV == 12'h898 + 12'h064 * $past(DEPLETED_CELL_THRESHOLD))
		else $error("cell mv");
	AST_ALERT_SET: assert property (STATUS_BITS != $past(STATUS_BITS) |-> ALERT_N_OE)
		else $error("alert not set");
	AST_ALERT_HOLD: assert property ($past(ALERT_N_OE) && !$past(STATUS_RD) |-> ALERT_N_OE)
		else $error("alert dropped");
	cover property (RESTORE_DEFAULTS);
	cover property ($fell(ALERT_N_OE));
	cover property (CHARGER_EN);
endmodule

bind cmc_mode_ctrl cmc_mode_ctrl_monitor mon_u (
	.CLK_SYS(CLK_SYS),
	.RST_B(RST_B),
	.WR_VALID(WR_VALID),
	.WR_CMD(WR_CMD),
	.WR_DATA(WR_DATA),
	.STATUS_RD(STATUS_RD),
	.CHARGE_ENABLE_PIN_N(CHARGE_ENABLE_PIN_N),
	.CHARGER_EN(CHARGER_EN),
	.RESTORE_DEFAULTS(RESTORE_DEFAULTS),
	.SWITCH_FREQ_SEL(SWITCH_FREQ_SEL),
	.ADAPTER_OVERCURRENT_GUARD(ADAPTER_OVERCURRENT_GUARD),
	.OVERCURRENT_TRIP_MA(OVERCURRENT_TRIP_MA),
	.DEPLETED_CELL_THRESHOLD(DEPLETED_CELL_THRESHOLD),
	.DEPLETED_CELL_MV(DEPLETED_CELL_MV),
	.STATUS_BITS(STATUS_BITS),
	.ALERT_N_OE(ALERT_N_OE)
);

`default_nettype wire

// File: verif/cmc_host_model.sv
// Host model: mode word writes and status reads on the command port.
// Assumes the bench calls its tasks and shares the system clock.
`default_nettype none

module cmc_host_model (
	input wire logic CLK_SYS,
	output logic WR_VALID,
	output logic [7:0] WR_CMD,
	output logic [15:0] WR_DATA,
	output logic STATUS_RD
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		WR_VALID = 1'b0;
		WR_CMD = 8'h00;
		WR_DATA = 16'h0000;
		STATUS_RD = 1'b0;
	end
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		@(posedge CLK_SYS);
		WR_VALID <= 1'b1;
		WR_CMD <= c;
		WR_DATA <= d;
		@(posedge CLK_SYS);
		WR_VALID <= 1'b0;
		// Idle bus shows the inverse, never a stale word
		WR_DATA <= ~d;
	endtask
	// constant-current pack: regulation voltage at its 19.2 V ceiling
	task automatic set_cc_only_pack;
		wr(8'h15, 16'h4B00);
	endtask
	task automatic rd;
		@(posedge CLK_SYS);
		STATUS_RD <= 1'b1;
		@(posedge CLK_SYS);
		STATUS_RD <= 1'b0;
	endtask
endmodule

`default_nettype wire

// File: verif/charger_mode_control_register_tb_top.sv
// Self-checking bench for the charger mode control word block.
// Assumes the host model and bound checker are compiled before it.
`default_nettype none

module charger_mode_control_register_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic CLK_SYS = 1'b0, RST_B = 1'b0, CHARGE_ENABLE_PIN_N = 1'b1, ADAPTER_PRESENT = 1'b1;
	logic CELL_BELOW_DEPLETED = 1'b0, WR_VALID, STATUS_RD, CHARGER_EN, RESTORE_DEFAULTS;
	logic CURRENT_MONITOR_OUT_SEL_CHARGE, LEARN_CYCLE, SWITCH_FREQ_SEL, ALERT_N_O, ALERT_N_OE;
	logic ADAPTER_OVERCURRENT_GUARD;
	logic [15:0] INPUT_CURRENT_LIMIT = 16'h03E8, WR_DATA, OVERCURRENT_TRIP_MA, STATUS_BITS;
	logic [7:0] WR_CMD;
	logic [1:0] OVERCURRENT_RATIO_SEL;
	logic [2:0] DEPLETED_CELL_THRESHOLD;
	logic [11:0] DEPLETED_CELL_MV;
	int errors = 0, n_checks = 0;
	always #50 CLK_SYS = ~CLK_SYS;
	cmc_host_model host_u (
		.CLK_SYS(CLK_SYS),
		.WR_VALID(WR_VALID),
		.WR_CMD(WR_CMD),
		.WR_DATA(WR_DATA),
		.STATUS_RD(STATUS_RD)
	);
	cmc_mode_ctrl dut_u (
		.CLK_SYS(CLK_SYS),
		.RST_B(RST_B),
		.WR_VALID(WR_VALID),
		.WR_CMD(WR_CMD),
		.WR_DATA(WR_DATA),
		.STATUS_RD(STATUS_RD),
		.INPUT_CURRENT_LIMIT(INPUT_CURRENT_LIMIT),
		.CHARGE_ENABLE_PIN_N(CHARGE_ENABLE_PIN_N),
		.ADAPTER_PRESENT(ADAPTER_PRESENT),
		.CELL_BELOW_DEPLETED(CELL_BELOW_DEPLETED),
		.CHARGER_EN(CHARGER_EN),
		.RESTORE_DEFAULTS(RESTORE_DEFAULTS),
		.CURRENT_MONITOR_OUT_SEL_CHARGE(CURRENT_MONITOR_OUT_SEL_CHARGE),
		.LEARN_CYCLE(LEARN_CYCLE),
		.SWITCH_FREQ_SEL(SWITCH_FREQ_SEL),
		.ADAPTER_OVERCURRENT_GUARD(ADAPTER_OVERCURRENT_GUARD),
		.OVERCURRENT_RATIO_SEL(OVERCURRENT_RATIO_SEL),
		.OVERCURRENT_TRIP_MA(OVERCURRENT_TRIP_MA),
		.DEPLETED_CELL_THRESHOLD(DEPLETED_CELL_THRESHOLD),
		.DEPLETED_CELL_MV(DEPLETED_CELL_MV),
		.STATUS_BITS(STATUS_BITS),
		.ALERT_N_O(ALERT_N_O),
		.ALERT_N_OE(ALERT_N_OE)
	);
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_sim;
		if (errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge CLK_SYS);
		#1;
	endtask
	task automatic t_enable;
		chk("monitor", CURRENT_MONITOR_OUT_SEL_CHARGE, 0);
		@(posedge CLK_SYS) CHARGE_ENABLE_PIN_N <= 1'b0;
		host_u.wr(8'h12, 16'h0000);
		tick(3);
		chk("on", {CHARGER_EN, STATUS_BITS[1]}, 2'b10);
		@(posedge CLK_SYS) CHARGE_ENABLE_PIN_N <= 1'b1;
		tick(4);
		chk("pin off", CHARGER_EN, 0);
	endtask
	task automatic t_fields;
		for (int k = 0; k < 8; k++) begin
			host_u.wr(8'h12, 16'hF07A | 16'(k << 9) | 16'(k % 4 << 7));
			tick(3);
			chk("ratio", OVERCURRENT_RATIO_SEL, 16'(k % 4));
			chk("mv", DEPLETED_CELL_MV, 16'(2200 + 100 * k));
			chk("trip", OVERCURRENT_TRIP_MA, 16'(1000 * (13 + 2 * (k % 4)) / 10));
			chk("bits", {CURRENT_MONITOR_OUT_SEL_CHARGE, LEARN_CYCLE, SWITCH_FREQ_SEL,
				ADAPTER_OVERCURRENT_GUARD, DEPLETED_CELL_THRESHOLD}, {4'hF, 3'(k)});
		end
		@(posedge CLK_SYS) INPUT_CURRENT_LIMIT <= 16'h07D0;
		tick(2);
		chk("trip scale", OVERCURRENT_TRIP_MA, 16'h0ED8);
		chk("learn", STATUS_BITS[6], 1);
		host_u.wr(8'h13, 16'h0000);
		tick(3);
		chk("other cmd", SWITCH_FREQ_SEL, 1);
		host_u.set_cc_only_pack;
		tick(3);
		chk("voltage cmd", SWITCH_FREQ_SEL, 1);
		host_u.wr(8'h12, 16'h0180);
		tick(3);
		chk("trip off", OVERCURRENT_TRIP_MA, 0);
	endtask
	task automatic t_restore;
		@(posedge CLK_SYS) CHARGE_ENABLE_PIN_N <= 1'b0;
		host_u.wr(8'h12, 16'h0068);
		tick(4);
		chk("on", CHARGER_EN, 1);
		host_u.wr(8'h12, 16'h0024);
		#1;
		for (int i = 0; i < 3 && RESTORE_DEFAULTS !== 1'b1; i++)
			tick(1);
		chk("pulse", RESTORE_DEFAULTS, 1);
		if (RESTORE_DEFAULTS !== 1'b1)
			end_sim;
		chk("defaults", {CURRENT_MONITOR_OUT_SEL_CHARGE, SWITCH_FREQ_SEL, ADAPTER_OVERCURRENT_GUARD}, 0);
		tick(1);
		chk("one shot", RESTORE_DEFAULTS, 0);
		tick(2);
		chk("stopped", CHARGER_EN, 0);
	endtask
	task automatic t_alert;
		host_u.rd;
		tick(2);
		chk("idle", ALERT_N_OE, 0);
		@(posedge CLK_SYS) ADAPTER_PRESENT <= 1'b0;
		tick(4);
		chk("alert", {STATUS_BITS[6], ALERT_N_OE, ALERT_N_O}, 3'b110);
		@(posedge CLK_SYS) CELL_BELOW_DEPLETED <= 1'b1;
		tick(4);
		chk("low", {STATUS_BITS[11], STATUS_BITS[7], ALERT_N_OE}, 3'b111);
		host_u.rd;
		tick(2);
		chk("cleared", ALERT_N_OE, 0);
	endtask
	initial begin
		repeat (16) @(posedge CLK_SYS);
		RST_B <= 1'b1;
		tick(2);
		chk("reset status", STATUS_BITS, 16'h0002);
		chk("reset alert", ALERT_N_OE, 0);
		t_enable;
		t_fields;
		t_restore;
		t_alert;
		end_sim;
	end
	initial begin
		repeat (3000) @(posedge CLK_SYS);
		errors++;
		end_sim;
	end
endmodule

`default_nettype wire
